/* File: include/hssb_regs.svh */
// Purpose: Command codes, bit positions and reset values of the status bank
// Assumes: Included by bare name from the interface and the flag latch and top modules
// Notes:   Definitions only
`ifndef HSSB_REGS_SVH
`define HSSB_REGS_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define HSSB_CMD_CLEAR_FAULTS 8'h03
`define HSSB_CMD_STATUS_BYTE 8'h78
`define HSSB_CMD_SUMMARY_WORD 8'h79
`define HSSB_CMD_OUTVOLT_STATUS 8'h7a
`define HSSB_CMD_OUTCURR_STATUS 8'h7b

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSSB_WORD_RESET 16'h0000
`define HSSB_BYTE_RESET 8'h00

// ----------------------------------------------------------------
// Summary word bit positions
// ----------------------------------------------------------------
`define HSSB_WORD_OUTVOLT_BIT 15
`define HSSB_WORD_OUTCURR_BIT 14
`define HSSB_WORD_INPUT_BIT 13
`define HSSB_WORD_VENDOR_BIT 12
`define HSSB_WORD_PWRBAD_BIT 11
`define HSSB_WORD_SWITCH_BIT 8

// ----------------------------------------------------------------
// Low byte bit positions
// ----------------------------------------------------------------
`define HSSB_BYTE_GATEOFF_BIT 6
`define HSSB_BYTE_OCSHUT_BIT 4
`define HSSB_BYTE_VINUV_BIT 3
`define HSSB_BYTE_TEMP_BIT 2
`define HSSB_BYTE_COMM_BIT 1
`define HSSB_BYTE_OTHER_BIT 0

// ----------------------------------------------------------------
// Detail register bit positions
// ----------------------------------------------------------------
`define HSSB_VOUT_OVW_BIT 6
`define HSSB_VOUT_UVW_BIT 5
`define HSSB_IOUT_OCSHUT_BIT 7
`define HSSB_IOUT_OCW_BIT 5

// Input status bit already reported by the low byte
`define HSSB_INPUT_UV_MASK 8'h10

// Number of latched flags
`define HSSB_NUM_FLAGS 7

`endif

/* File: include/hssb_pkg.sv */
// Purpose: Types shared by the status bank modules
// Assumes: Flag count matches the header
// Notes:   Field order fixes the flag vector layout
package hssb_pkg;

   // ----------------------------------------------------------------
   // Latched flags, msb first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic comm_error;
      logic vin_uv;
      logic pass_switch;
      logic oc_warn;
      logic oc_shutdown;
      logic uv_warn;
      logic ov_warn;
   } hssb_flags_t;

   typedef logic [7:0] hssb_byte_t;
   typedef logic [15:0] hssb_word_t;

endpackage

/* File: include/hssb_flag_if.sv */
// Purpose: Carrier between the bank and its sticky flag store
// Assumes: One set bit per flag, one common clear
// Notes:   No clocking block; the store is clocked by its own ports
`timescale 1ns/1ns
`default_nettype none
`include "hssb_regs.svh"

interface hssb_flag_if;
   logic [`HSSB_NUM_FLAGS-1:0] set;
   logic clr;
   logic [`HSSB_NUM_FLAGS-1:0] q;

   modport store (input set, input clr, output q);
   modport user (output set, output clr, input q);
endinterface

`default_nettype wire

/* File: hdl/hssb_flag_latch.sv */
// Purpose: Sticky flag store for the status bank
// Assumes: Set levels are condition levels, clear is a one-cycle pulse
// Notes:   Set wins over clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "hssb_regs.svh"

module hssb_flag_latch (
   input wire logic clk_sys,
   input wire logic reset,
   hssb_flag_if.store fl
);

   logic [`HSSB_NUM_FLAGS-1:0] q_r;
   logic [`HSSB_NUM_FLAGS-1:0] q_nxt;

   // ----------------------------------------------------------------
   // One sticky bit per flag
   // ----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `HSSB_NUM_FLAGS; i++) begin : g_flag
         // Still-present condition keeps the bit set through a clear
         assign q_nxt[i] = fl.set[i] ? 1'b1 : (fl.clr ? 1'b0 : q_r[i]);
      end
   endgenerate

   // One process owns the whole vector, so each bit has a single writer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign fl.q = q_r;

endmodule

`default_nettype wire

/* File: hdl/hssb_top.sv */
// Purpose: Status reporting bank of a hot swap controller
// Assumes: Host transactions arrive already decoded as command pulses
// Notes:   Reads answer one cycle after the request with a snapshot
//
// Operation
// - Word bit 15 is high exactly while any output voltage status bit is set.
// - Word bit 14 is high exactly while any output current status bit is set.
// - Word bit 13 is high exactly while any input status bit is set.
// - Word bit 12 is high exactly while any vendor specific status bit is set.
// - Word bit 11 is high while the power good sense is below threshold.
// - Word bit 8 latches a pass switch health fault and stays set until a clear command.
// - The word's low byte equals the status byte and bits 10:9, 7 and 5 read 0.
// - Reserved bits of the voltage and current status registers read 0.
// - Voltage status bit 6 latches on an output overvoltage warning.
// - Voltage status bit 5 latches on an output undervoltage warning.
// - Current status bit 7 and low byte bit 4 latch on an overcurrent shutdown.
// - Current status bit 5 latches when current exceeds the warning threshold.
// - Low byte bit 1 latches on an unsupported command, bad PEC or bad message.
// - Low byte bit 0 shows some other detail status bit is pending.
// - Low byte bit 6 shows the gate pulldown is active, the UV pin is below threshold or the output is commanded off.
`timescale 1ns/1ns
`default_nettype none
`include "hssb_regs.svh"

module hssb_top
   import hssb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic host_cmd_valid,
   input wire logic [7:0] host_cmd_code,
   input wire logic host_cmd_read,
   input wire logic host_pec_error,
   input wire logic host_frame_error,
   output logic rd_valid,
   output logic rd_nack,
   output logic rd_two_bytes,
   output logic [15:0] rd_data,
   input wire logic output_overvoltage_warning_cond,
   input wire logic output_undervoltage_warning_cond,
   input wire logic oc_timer_expired_cond,
   input wire logic iout_over_warn_cond,
   input wire logic pass_switch_health_cond,
   input wire logic input_undervoltage_cond,
   input wire logic uv_pin_below,
   input wire logic output_off_cmd,
   input wire logic gate_pulldown_active,
   input wire logic power_good_sense_input,
   input wire logic [7:0] input_status_in,
   input wire logic [7:0] temp_status_in,
   input wire logic [7:0] vendor_summary_flag_in
);

   // ----------------------------------------------------------------
   // Command decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_status_read(input logic [7:0] code);
      is_status_read = (code == `HSSB_CMD_STATUS_BYTE) || (code == `HSSB_CMD_SUMMARY_WORD) ||
                       (code == `HSSB_CMD_OUTVOLT_STATUS) || (code == `HSSB_CMD_OUTCURR_STATUS);
   endfunction

   function automatic logic is_supported(input logic [7:0] code, input logic rd);
      is_supported = rd ? is_status_read(code) : (code == `HSSB_CMD_CLEAR_FAULTS);
   endfunction

   // ----------------------------------------------------------------
   // Sticky flag store
   // ----------------------------------------------------------------
   hssb_flag_if flags_if ();

   hssb_flag_latch u_flags (
      .clk_sys(clk_sys),
      .reset(reset),
      .fl(flags_if.store)
   );

   hssb_flags_t flag_set;
   hssb_flags_t flag_q;
   wire logic msg_error;
   wire logic cmd_unsupported;
   wire logic clear_cmd;

   // Host side error sources
   assign msg_error = host_pec_error | host_frame_error;
   assign cmd_unsupported = host_cmd_valid & ~is_supported(host_cmd_code, host_cmd_read);
   // A clear spoiled by a bus error is not acted on
   assign clear_cmd = host_cmd_valid & ~host_cmd_read & ~msg_error &
                      (host_cmd_code == `HSSB_CMD_CLEAR_FAULTS);

   // Condition levels feeding the sticky bits
   always_comb begin
      flag_set = '0;
      flag_set.ov_warn = output_overvoltage_warning_cond;
      flag_set.uv_warn = output_undervoltage_warning_cond;
      flag_set.oc_shutdown = oc_timer_expired_cond;
      flag_set.oc_warn = iout_over_warn_cond;
      flag_set.pass_switch = pass_switch_health_cond;
      flag_set.vin_uv = input_undervoltage_cond;
      flag_set.comm_error = cmd_unsupported | msg_error;
   end

   assign flags_if.set = flag_set;
   assign flags_if.clr = clear_cmd;
   assign flag_q = flags_if.q;

   // ----------------------------------------------------------------
   // Detail registers
   // ----------------------------------------------------------------
   hssb_byte_t outvolt_status;
   hssb_byte_t outcurr_status;

   // Only documented bits are placed; all others stay zero
   always_comb begin
      outvolt_status = `HSSB_BYTE_RESET;
      outvolt_status[`HSSB_VOUT_OVW_BIT] = flag_q.ov_warn;
      outvolt_status[`HSSB_VOUT_UVW_BIT] = flag_q.uv_warn;
      outcurr_status = `HSSB_BYTE_RESET;
      outcurr_status[`HSSB_IOUT_OCSHUT_BIT] = flag_q.oc_shutdown;
      outcurr_status[`HSSB_IOUT_OCW_BIT] = flag_q.oc_warn;
   end

   // ----------------------------------------------------------------
   // Live summaries
   // ----------------------------------------------------------------
   wire logic outvolt_summary_flag;
   wire logic outcurr_summary_flag;
   wire logic input_summary_flag;
   wire logic vendor_summary_flag;
   wire logic power_bad_flag;
   wire logic gate_drive_disabled_flag;
   wire logic temp_summary_flag;
   wire logic other_pending_flag;

   assign outvolt_summary_flag = |outvolt_status;
   assign outcurr_summary_flag = |outcurr_status;
   assign input_summary_flag = |input_status_in;
   // Switch health lives in the vendor register too
   assign vendor_summary_flag = (|vendor_summary_flag_in) | flag_q.pass_switch;
   assign power_bad_flag = ~power_good_sense_input;
   assign gate_drive_disabled_flag = gate_pulldown_active | uv_pin_below | output_off_cmd;
   assign temp_summary_flag = |temp_status_in;
   // Anything a detail read would show that no other low byte bit covers
   assign other_pending_flag = outvolt_summary_flag | flag_q.oc_warn | vendor_summary_flag |
                               (|(input_status_in & ~`HSSB_INPUT_UV_MASK));

   // ----------------------------------------------------------------
   // Status byte and summary word
   // ----------------------------------------------------------------
   hssb_byte_t status_byte;
   hssb_word_t summary_status_word;

   always_comb begin
      status_byte = `HSSB_BYTE_RESET;
      status_byte[`HSSB_BYTE_GATEOFF_BIT] = gate_drive_disabled_flag;
      status_byte[`HSSB_BYTE_OCSHUT_BIT] = flag_q.oc_shutdown;
      status_byte[`HSSB_BYTE_VINUV_BIT] = flag_q.vin_uv;
      status_byte[`HSSB_BYTE_TEMP_BIT] = temp_summary_flag;
      status_byte[`HSSB_BYTE_COMM_BIT] = flag_q.comm_error;
      status_byte[`HSSB_BYTE_OTHER_BIT] = other_pending_flag;
   end

   always_comb begin
      summary_status_word = `HSSB_WORD_RESET;
      summary_status_word[7:0] = status_byte;
      summary_status_word[`HSSB_WORD_OUTVOLT_BIT] = outvolt_summary_flag;
      summary_status_word[`HSSB_WORD_OUTCURR_BIT] = outcurr_summary_flag;
      summary_status_word[`HSSB_WORD_INPUT_BIT] = input_summary_flag;
      summary_status_word[`HSSB_WORD_VENDOR_BIT] = vendor_summary_flag;
      summary_status_word[`HSSB_WORD_PWRBAD_BIT] = power_bad_flag;
      summary_status_word[`HSSB_WORD_SWITCH_BIT] = flag_q.pass_switch;
   end

   // ----------------------------------------------------------------
   // Read answer path
   // ----------------------------------------------------------------
   wire logic read_req;
   wire logic read_ok;
   hssb_word_t read_sel;
   logic rd_valid_r;
   logic rd_nack_r;
   logic rd_two_bytes_r;
   logic [15:0] rd_data_r;

   assign read_req = host_cmd_valid & host_cmd_read;
   assign read_ok = read_req & is_status_read(host_cmd_code);
   // Byte registers come back zero extended
   assign read_sel = (host_cmd_code == `HSSB_CMD_SUMMARY_WORD) ? summary_status_word :
                     (host_cmd_code == `HSSB_CMD_OUTVOLT_STATUS) ? {8'h00, outvolt_status} :
                     (host_cmd_code == `HSSB_CMD_OUTCURR_STATUS) ? {8'h00, outcurr_status} :
                     {8'h00, status_byte};

   // Snapshot taken at the request edge, so it shows pre-edge state
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_valid_r <= 1'b0;
         rd_nack_r <= 1'b0;
         rd_two_bytes_r <= 1'b0;
         rd_data_r <= `HSSB_WORD_RESET;
      end else begin
         rd_valid_r <= read_ok;
         rd_nack_r <= read_req & ~read_ok;
         if (read_ok) begin
            rd_two_bytes_r <= (host_cmd_code == `HSSB_CMD_SUMMARY_WORD);
            rd_data_r <= read_sel;
         end
      end
   end

   assign rd_valid = rd_valid_r;
   assign rd_nack = rd_nack_r;
   assign rd_two_bytes = rd_two_bytes_r;
   assign rd_data = rd_data_r;

endmodule

`default_nettype wire

/* File: verification/hssb_checker_assertions.sv */
// Purpose: Port level checks of the status bank
// Assumes: Answers registered one edge after the request edge
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none

module hssb_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic host_cmd_valid,
   input wire logic [7:0] host_cmd_code,
   input wire logic host_cmd_read,
   input wire logic host_pec_error,
   input wire logic rd_valid,
   input wire logic rd_nack,
   input wire logic rd_two_bytes,
   input wire logic [15:0] rd_data,
   input wire logic oc_timer_expired_cond,
   input wire logic power_good_sense_input,
   input wire logic gate_pulldown_active,
   input wire logic uv_pin_below,
   input wire logic output_off_cmd,
   input wire logic [7:0] input_status_in,
   input wire logic [7:0] vendor_summary_flag_in
);
   // ----------------------------------------------------------------
   // Request decode
   // ----------------------------------------------------------------
   // Codes 0x78 to 0x7b share the upper six bits
   wire logic rd_ok = host_cmd_valid && host_cmd_read && host_cmd_code[7:2] == 6'h1e;
   wire logic rd_bad = host_cmd_valid && host_cmd_read && !rd_ok;
   wire logic word_ans = rd_valid && rd_two_bytes;

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_read_answered: assert property (rd_ok |=> rd_valid && !rd_nack)
      else $error("supported read not answered");
   a_bad_read_refused: assert property (rd_bad |=> rd_nack && !rd_valid)
      else $error("unsupported read not refused");
   a_word_reserved_zero: assert property (word_ans |-> (rd_data & 16'h06a0) == 16'h0000)
      else $error("reserved word bit set");
   a_detail_reserved_zero: assert property (rd_valid && $past(host_cmd_code[7:1]) == 7'h3d
      |-> (rd_data & ($past(host_cmd_code[0]) ? 16'hff5f : 16'hff9f)) == 16'h0000)
      else $error("reserved detail bit set");
   a_power_bad_live: assert property (word_ans |-> rd_data[11] == !$past(power_good_sense_input))
      else $error("power bad bit wrong");
   a_gate_off_live: assert property (word_ans |-> rd_data[6] == ($past(gate_pulldown_active)
      || $past(uv_pin_below) || $past(output_off_cmd)))
      else $error("gate off bit wrong");
   a_oc_shut_latched: assert property (!$past(reset, 2) && !$past(reset)
      && $past(oc_timer_expired_cond, 2) && rd_valid && $past(host_cmd_code) == 8'h7b |-> rd_data[7])
      else $error("overcurrent shutdown not latched");
   a_comm_latched: assert property (!$past(reset, 2) && !$past(reset)
      && $past(host_pec_error, 2) && word_ans |-> rd_data[1])
      else $error("comm error not latched");
   a_input_live: assert property (word_ans |-> rd_data[13] == ($past(input_status_in) != 8'h00))
      else $error("input summary bit wrong");
   a_vendor_live: assert property (word_ans && $past(vendor_summary_flag_in) != 8'h00 |-> rd_data[12])
      else $error("vendor summary bit wrong");
endmodule

bind hssb_top hssb_checker u_checker (.*);

`default_nettype wire

/* File: verification/hssb_host_model.sv */
// Purpose: Host model issuing decoded status commands
// Assumes: Every task is entered at a falling clock edge
// Notes:   Idle code lines show the inverse of the last code
`timescale 1ns/1ns
`default_nettype none

module hssb_host_model (
   input wire logic clk_sys,
   input wire logic rd_valid,
   input wire logic rd_nack,
   input wire logic [15:0] rd_data,
   output var logic host_cmd_valid,
   output var logic [7:0] host_cmd_code,
   output var logic host_cmd_read,
   output var logic host_pec_error,
   output var logic host_frame_error
);
   // Idle at time zero
   initial begin
      host_cmd_valid = 1'b0;
      host_cmd_code = 8'h00;
      host_cmd_read = 1'b0;
      host_pec_error = 1'b0;
      host_frame_error = 1'b0;
   end

   // Request held across one rising edge; code inverted after so it never looks fresh
   task automatic issue(input logic [7:0] c, input logic r);
      host_cmd_code = c;
      host_cmd_read = r;
      host_cmd_valid = 1'b1;
      @(negedge clk_sys);
      host_cmd_valid = 1'b0;
      host_cmd_code = ~c;
   endtask

   // Answer taken once settled, waiting two falling edges at most
   // An idle edge follows so the next request never re-raises valid in the same step
   task automatic read(input logic [7:0] c, output logic [15:0] d, output logic nk,
                       output logic vl);
      issue(c, 1'b1);
      for (int i = 0; i < 2 && !(rd_valid || rd_nack); i++) begin
         @(negedge clk_sys);
      end
      d = rd_data;
      nk = rd_nack;
      vl = rd_valid;
      @(negedge clk_sys);
   endtask

   // Fault clearing command, then one idle edge
   task automatic clear_faults();
      issue(8'h03, 1'b0);
      @(negedge clk_sys);
   endtask

   // Bus error pulse: 0 bad check byte, 1 malformed message
   task automatic bus_error(input logic frame);
      host_pec_error = !frame;
      host_frame_error = frame;
      @(negedge clk_sys);
      host_pec_error = 1'b0;
      host_frame_error = 1'b0;
   endtask
endmodule

`default_nettype wire

/* File: verification/test_hot_swap_status_summary_bank.sv */
// Purpose: Self-checking bench of the status bank
// Assumes: Inputs change at falling edges only
// Notes:   Expected words built by hand from bit positions
`timescale 1ns/1ns
`default_nettype none

module test_hot_swap_status_summary_bank;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic host_cmd_valid, host_cmd_read, host_pec_error, host_frame_error;
   logic [7:0] host_cmd_code;
   logic rd_valid, rd_nack, rd_two_bytes;
   logic [15:0] rd_data;
   logic output_overvoltage_warning_cond = 1'b0, output_undervoltage_warning_cond = 1'b0;
   logic oc_timer_expired_cond = 1'b0, input_undervoltage_cond = 1'b0;
   logic iout_over_warn_cond = 1'b0, pass_switch_health_cond = 1'b0;
   logic uv_pin_below = 1'b0, output_off_cmd = 1'b0, gate_pulldown_active = 1'b0;
   logic power_good_sense_input = 1'b1;
   logic [7:0] input_status_in = 8'h00, temp_status_in = 8'h00, vendor_summary_flag_in = 8'h00;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;

   hssb_top DUT (.*);
   hssb_host_model HOST (.*);

   // ----------------------------------------------------------------
   // Clock, timeout, verdict
   // ----------------------------------------------------------------
   always #10 clk_sys = ~clk_sys;

   // Whole run is about 115 cycles; far margin against a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Compare and read helpers
   // ----------------------------------------------------------------
   task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cmp1(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   task automatic chk(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] d;
      logic nk;
      logic vl;
      HOST.read(c, d, nk, vl);
      cmp1("nack", 1'b0, nk);
      cmp1("valid", 1'b1, vl);
      cmp1("two bytes", c == 8'h79, rd_two_bytes);
      cmp16($sformatf("read %h", c), exp, d);
   endtask

   // Byte read must equal the word's low half
   task automatic expect_all(input logic [15:0] w, input logic [7:0] v, input logic [7:0] i);
      chk(8'h79, w);
      chk(8'h78, {8'h00, w[7:0]});
      chk(8'h7a, {8'h00, v});
      chk(8'h7b, {8'h00, i});
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Latched warnings and faults, then clear with a condition still high
   task automatic t_latch();
      output_overvoltage_warning_cond = 1'b1;
      @(negedge clk_sys);
      output_overvoltage_warning_cond = 1'b0;
      output_undervoltage_warning_cond = 1'b1;
      @(negedge clk_sys);
      output_undervoltage_warning_cond = 1'b0;
      expect_all(16'h8001, 8'h60, 8'h00);
      oc_timer_expired_cond = 1'b1;
      @(negedge clk_sys);
      oc_timer_expired_cond = 1'b0;
      chk(8'h7b, 16'h0080);
      iout_over_warn_cond = 1'b1;
      @(negedge clk_sys);
      iout_over_warn_cond = 1'b0;
      expect_all(16'hc011, 8'h60, 8'ha0);
      HOST.clear_faults();
      expect_all(16'h0000, 8'h00, 8'h00);
      output_overvoltage_warning_cond = 1'b1;
      @(negedge clk_sys);
      HOST.clear_faults();
      output_overvoltage_warning_cond = 1'b0;
      chk(8'h7a, 16'h0040);
   endtask

   // Live summaries follow their sources with no latching
   task automatic t_live();
      HOST.clear_faults();
      power_good_sense_input = 1'b0;
      chk(8'h79, 16'h0800);
      power_good_sense_input = 1'b1;
      vendor_summary_flag_in = 8'h01;
      chk(8'h79, 16'h1001);
      vendor_summary_flag_in = 8'h00;
      input_status_in = 8'h10;
      chk(8'h79, 16'h2000);
      input_status_in = 8'h01;
      chk(8'h79, 16'h2001);
      input_status_in = 8'h00;
      temp_status_in = 8'h80;
      chk(8'h78, 16'h0004);
      temp_status_in = 8'h00;
      for (int k = 0; k < 3; k++) begin
         {gate_pulldown_active, uv_pin_below, output_off_cmd} = 3'b001 << k;
         chk(8'h79, 16'h0040);
      end
      {gate_pulldown_active, uv_pin_below, output_off_cmd} = 3'b000;
      chk(8'h79, 16'h0000);
   endtask

   // Switch health and input undervoltage stay set after the cause leaves
   task automatic t_switch();
      pass_switch_health_cond = 1'b1;
      input_undervoltage_cond = 1'b1;
      @(negedge clk_sys);
      pass_switch_health_cond = 1'b0;
      input_undervoltage_cond = 1'b0;
      chk(8'h79, 16'h1109);
      HOST.clear_faults();
      chk(8'h79, 16'h0000);
   endtask

   // Every kind of communication error latches bit 1 until cleared
   task automatic t_comm();
      logic [15:0] d;
      logic nk;
      logic vl;
      for (int k = 0; k < 4; k++) begin
         if (k == 0) begin
            HOST.read(8'h55, d, nk, vl);
            cmp1("nack", 1'b1, nk);
            cmp1("valid", 1'b0, vl);
         end else if (k == 3) begin
            HOST.issue(8'h20, 1'b0);
            @(negedge clk_sys);
         end else begin
            HOST.bus_error(k == 2);
         end
         chk(8'h79, 16'h0002);
         HOST.clear_faults();
      end
      chk(8'h78, 16'h0000);
   endtask

   // Reset in mid-run drops a latched fault and the held answer
   task automatic t_reset();
      oc_timer_expired_cond = 1'b1;
      @(negedge clk_sys);
      oc_timer_expired_cond = 1'b0;
      chk(8'h7b, 16'h0080);
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      cmp16("held answer", 16'h0000, rd_data);
      reset = 1'b0;
      expect_all(16'h0000, 8'h00, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk_sys);
      reset = 1'b0;
      expect_all(16'h0000, 8'h00, 8'h00);
      t_latch();
      t_live();
      t_switch();
      t_comm();
      t_reset();
      give_verdict();
   end
endmodule

`default_nettype wire
